/* File: core/irfmc_bank_decode.sv */
// Decoder from the bank select register to the selected bank number.
module irfmc_bank_decode
	import irfmc_pkg::*;
(
	input  wire logic [7:0] bank_reg,
	output logic      [2:0] bank
);

	logic [2:0] code;

	assign code = bank_reg[4:2];

	// Codes not in the table fall back to bank 0 so that the shared address reads the bank register.
	always_comb begin
		bank = BANK_ZERO;
		if (!bank_reg[BSC_DEC_BIT]) begin
			bank = BANK_ZERO;
		end else if (!bank_reg[6] || bank_reg[1] || bank_reg[0]) begin
			bank = BANK_ONE;
		end else if (bank_reg[5] && (code <= BANK_CODE_MAX)) begin
			bank = 3'(code + BANK_CODE_OFS);
		end else begin
			bank = BANK_ZERO;
		end
	end

endmodule : irfmc_bank_decode

/* File: core/irfmc_ctrl.sv */
// Top of the infrared line format, bank and mode control block with its Avalon-MM slave.
//
// The Avalon-MM register port is this design's own decision.
module irfmc_ctrl
	import irfmc_pkg::*;
(
	input  wire logic                       REF_CLK,
	input  wire logic                       RST,
	input  wire logic [irfmc_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic                       AVS_READ,
	input  wire logic                       AVS_WRITE,
	input  wire logic [31:0]                AVS_WRITEDATA,
	input  wire logic [3:0]                 AVS_BYTEENABLE,
	output logic      [31:0]                AVS_READDATA,
	output logic                            AVS_WAITREQUEST,
	input  wire logic                       TX_SERIAL_DATA,
	input  wire logic                       TRANSMIT_ALL_EMPTY_FLAG,
	output logic                            SERIAL_OUT_PIN,
	output logic                            DIVISOR_ACCESS_SELECT,
	output logic                            FORMAT_ACTIVE,
	output logic      [3:0]                 DATA_BITS,
	output logic      [2:0]                 TX_STOP_HALF_BITS,
	output logic      [1:0]                 RX_STOP_BITS_OUT,
	output logic                            PARITY_ON,
	output logic                            STICK_PARITY,
	output logic                            PARITY_POLARITY_SELECT,
	output logic      [2:0]                 OPERATING_MODE_SELECT,
	output logic                            INTERACTION_PULSE_SEND,
	output logic                            TRANSMIT_DELAY_ON
);

	//--------------------------------------------------------------------------
	// State
	//--------------------------------------------------------------------------
	typedef struct packed {
		irfmc_bus_t  bus;
		logic [31:0] rdata;
		logic [7:0]  bsc;
		logic [7:0]  lfc;
		logic [7:0]  omc;
		logic        ext;
		logic        serial_out_pin;
		logic        div_acc;
		logic        fmt_act;
		logic [3:0]  dbits;
		logic [2:0]  stop_half;
		logic [1:0]  rx_stop;
		logic        par_on;
		logic        par_stick;
		logic        par_even;
		irfmc_mode_t mode;
		logic        pulse;
		logic        txdelay;
	} irfmc_state_t;

	localparam irfmc_state_t ST_RESET = '{
		bus:       IRFMC_BUS_IDLE,
		rdata:     RDATA_RESET,
		bsc:       BSC_RESET,
		lfc:       LFC_RESET,
		omc:       OMC_RESET,
		ext:       EXT_RESET,
		serial_out_pin:      1'b1,
		div_acc:   1'b0,
		fmt_act:   1'b1,
		dbits:     MIN_DATA_BITS,
		stop_half: STOP_HALF_ONE,
		rx_stop:   RX_STOP_BITS,
		par_on:    1'b0,
		par_stick: 1'b0,
		par_even:  1'b0,
		mode:      IRFMC_MODE_UART,
		pulse:     1'b0,
		txdelay:   1'b0
	};

	irfmc_state_t st_r;
	irfmc_state_t st_nxt;

	logic [2:0]  bank;
	logic [3:0]  dbits_dec;
	logic [2:0]  stop_dec;
	logic [1:0]  rx_stop_dec;
	logic        par_on_dec;
	logic        par_stick_dec;
	logic        par_even_dec;
	irfmc_mode_t mode_eff;
	logic        fast_mode;
	logic        req;
	logic        wr_lane0;
	logic [7:0]  wbyte;

	//--------------------------------------------------------------------------
	// Decoders
	//--------------------------------------------------------------------------
	irfmc_bank_decode u_bank (
		.bank_reg (st_r.bsc),
		.bank     (bank)
	);

	irfmc_fmt_decode u_fmt (
		.fmt_reg        (st_r.lfc),
		.data_bits      (dbits_dec),
		.stop_half_bits (stop_dec),
		.rx_stop_bits   (rx_stop_dec),
		.par_on         (par_on_dec),
		.par_stick      (par_stick_dec),
		.par_even       (par_even_dec)
	);

	// Outside extended mode the mode register is ignored and UART is in force.
	assign mode_eff  = st_r.ext ? irfmc_mode_t'(st_r.omc[OMC_MODE_LSB +: 3]) : IRFMC_MODE_UART;
	assign fast_mode = (mode_eff == IRFMC_MODE_MIR) || (mode_eff == IRFMC_MODE_FIR);
	assign req       = AVS_READ || AVS_WRITE;
	assign wr_lane0  = AVS_WRITE && AVS_BYTEENABLE[0];
	assign wbyte     = AVS_WRITEDATA[7:0];

	//--------------------------------------------------------------------------
	// Next state
	//--------------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;

		// Every request waits one cycle; the answer and any write land on the edge waitrequest is low.
		case (st_r.bus)
			IRFMC_BUS_IDLE: begin
				if (req) begin
					st_nxt.bus   = IRFMC_BUS_ANSWER;
					st_nxt.rdata = RDATA_RESET;
					if (AVS_READ) begin
						case (AVS_ADDRESS)
							LFC_IDX: begin
								st_nxt.rdata[7:0] = (bank == BANK_LFC_READ) ? st_r.lfc : st_r.bsc;
							end
							MLC_IDX: begin
								st_nxt.rdata[7:0] = st_r.ext ? st_r.omc : 8'h00;
							end
							EXT_IDX: begin
								st_nxt.rdata[EXT_ON_BIT] = st_r.ext;
							end
							STAT_IDX: begin
								st_nxt.rdata[STAT_MODE_LSB +: 3] = mode_eff;
								st_nxt.rdata[STAT_BANK_LSB +: 3] = bank;
								st_nxt.rdata[STAT_TE_BIT]        = TRANSMIT_ALL_EMPTY_FLAG;
								st_nxt.rdata[STAT_EXT_BIT]       = st_r.ext;
							end
							default: begin
								st_nxt.rdata = RDATA_RESET;
							end
						endcase
					end
				end
			end
			IRFMC_BUS_ANSWER: begin
				st_nxt.bus = IRFMC_BUS_IDLE;
				if (wr_lane0) begin
					case (AVS_ADDRESS)
						LFC_IDX: begin
							st_nxt.bsc = wbyte;
							if (!wbyte[LFC_DIV_BIT]) begin
								st_nxt.lfc = wbyte;
							end
						end
						MLC_IDX: begin
							// Without extended mode this is the modem register, which holds nothing.
							if (st_r.ext) begin
								st_nxt.omc = wbyte & OMC_WR_MASK;
							end
						end
						EXT_IDX: begin
							st_nxt.ext = wbyte[EXT_ON_BIT];
						end
						default: begin
							st_nxt.bus = IRFMC_BUS_IDLE;
						end
					endcase
				end
			end
			default: begin
				st_nxt.bus = IRFMC_BUS_IDLE;
			end
		endcase

		//----------------------------------------------------------------------
		// Outputs toward the serial engine
		//----------------------------------------------------------------------
		// The line format is marked active for the engine only in UART and SIR.
		st_nxt.fmt_act   = (mode_eff == IRFMC_MODE_UART) || (mode_eff == IRFMC_MODE_SIR);
		// A shared write with bit 7 set only reaches the bank register, so the latch select is taken from there.
		st_nxt.div_acc   = st_r.bsc[LFC_DIV_BIT];
		st_nxt.dbits     = dbits_dec;
		st_nxt.stop_half = stop_dec;
		st_nxt.rx_stop   = rx_stop_dec;
		st_nxt.par_on    = par_on_dec;
		st_nxt.par_stick = par_stick_dec;
		st_nxt.par_even  = par_even_dec;
		// The pin is registered, so it trails the engine by one cycle.
		st_nxt.serial_out_pin      = (st_r.lfc[LFC_BRK_BIT] && (mode_eff == IRFMC_MODE_UART)) ? 1'b0 : TX_SERIAL_DATA;
		st_nxt.mode      = mode_eff;
		st_nxt.pulse     = fast_mode && st_r.omc[OMC_SIP_BIT];
		st_nxt.txdelay   = fast_mode && st_r.omc[OMC_TRANSMIT_DELAY_ON_BIT];
	end

	//--------------------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign AVS_READDATA           = st_r.rdata;
	assign AVS_WAITREQUEST        = (st_r.bus == IRFMC_BUS_IDLE);
	assign SERIAL_OUT_PIN         = st_r.serial_out_pin;
	assign DIVISOR_ACCESS_SELECT  = st_r.div_acc;
	assign FORMAT_ACTIVE          = st_r.fmt_act;
	assign DATA_BITS              = st_r.dbits;
	assign TX_STOP_HALF_BITS      = st_r.stop_half;
	assign RX_STOP_BITS_OUT       = st_r.rx_stop;
	assign PARITY_ON              = st_r.par_on;
	assign STICK_PARITY           = st_r.par_stick;
	assign PARITY_POLARITY_SELECT = st_r.par_even;
	assign OPERATING_MODE_SELECT  = st_r.mode;
	assign INTERACTION_PULSE_SEND = st_r.pulse;
	assign TRANSMIT_DELAY_ON      = st_r.txdelay;

endmodule : irfmc_ctrl

/* File: core/irfmc_fmt_decode.sv */
// Decoder from the line format register to character format figures.
module irfmc_fmt_decode
	import irfmc_pkg::*;
(
	input  wire logic [7:0] fmt_reg,
	output logic      [3:0] data_bits,
	output logic      [2:0] stop_half_bits,
	output logic      [1:0] rx_stop_bits,
	output logic            par_on,
	output logic            par_stick,
	output logic            par_even
);

	logic [1:0] wl;

	assign wl             = fmt_reg[LFC_WL_LSB +: 2];
	assign data_bits      = 4'(MIN_DATA_BITS + {2'b00, wl});
	assign rx_stop_bits   = RX_STOP_BITS;
	assign par_on         = fmt_reg[LFC_PAR_BIT];
	assign par_stick      = fmt_reg[LFC_PAR_BIT] & fmt_reg[LFC_STICK_BIT];
	assign par_even       = fmt_reg[LFC_POL_BIT];

	// Stop length is counted in half bits so that the 1.5 case stays an integer.
	always_comb begin
		if (!fmt_reg[LFC_STOP_BIT]) begin
			stop_half_bits = STOP_HALF_ONE;
		end else if (wl == WL_FIVE) begin
			stop_half_bits = STOP_HALF_1P5;
		end else begin
			stop_half_bits = STOP_HALF_TWO;
		end
	end

endmodule : irfmc_fmt_decode

/* File: core/irfmc_pkg.sv */
// Package of constants and types for the infrared line format, bank and mode control block.
//------------------------------------------------------------------------------
// Overview of operation
// - Word length code 00..11 gives five to eight data bits, transmit and receive.
// - Stop-length 0 sends one stop bit; 1 sends 1.5 (five bits) else two.
// - Receiver checks exactly one stop bit regardless of the stop-length setting.
// - Parity-select 0 odd, 1 even; stick parity forces bit to parity-select value.
// - Break bit in UART mode forces serial output to 0; no effect elsewhere.
// - Bit 7 of line format routes accesses to the divisor latch registers.
// - Line format settings govern only UART and SIR modes, not MIR or FIR.
// - Bank-decode bit 0 selects bank 0; 1 decodes bank from seven-bit code.
// - Bit6 0 or bits1-0 nonzero gives bank 1; with bit5 set, codes 000..101 give banks 2..7.
// - Shared address reads line format only in bank 3, else bank register.
// - Shared write with bit7 0 loads both registers; bit7 1 loads bank only.
// - Modem control is unimplemented: reads zero, writes ignored, write only zeros.
// - Mode field: 000 UART, 011 SIR, 100 MIR, 101 FIR; others reserved.
// - Mode register has effect only while extended mode is on.
// - Interaction-pulse bit sends a pulse only in MIR and FIR modes.
// - Transmit-delay bit enables delayed start only in MIR and FIR modes.
// - Reset clears the mode register: UART, no pulse, no transmit delay.
// - Extended mode is in force only while bit 0 of extended control is 1.
//------------------------------------------------------------------------------
package irfmc_pkg;

	//--------------------------------------------------------------------------
	// Register map
	//--------------------------------------------------------------------------
	localparam int          ADDR_W         = 3;
	localparam logic [31:0] REG_BASE       = 32'hD870_0080;
	localparam logic [31:0] LFC_OFFSET     = 32'hD870_0083;
	localparam logic [31:0] MLC_OFFSET     = 32'hD870_0084;
	localparam logic [31:0] EXT_OFFSET     = 32'hD870_0086;
	localparam logic [31:0] STAT_OFFSET    = 32'hD870_0087;
	localparam logic [2:0]  LFC_IDX        = 3'(LFC_OFFSET - REG_BASE);
	localparam logic [2:0]  MLC_IDX        = 3'(MLC_OFFSET - REG_BASE);
	localparam logic [2:0]  EXT_IDX        = 3'(EXT_OFFSET - REG_BASE);
	localparam logic [2:0]  STAT_IDX       = 3'(STAT_OFFSET - REG_BASE);

	//--------------------------------------------------------------------------
	// Reset values
	//--------------------------------------------------------------------------
	localparam logic [7:0]  LFC_RESET      = 8'h00;
	localparam logic [7:0]  BSC_RESET      = 8'h00;
	localparam logic [7:0]  OMC_RESET      = 8'h00;
	localparam logic        EXT_RESET      = 1'b0;
	localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

	//--------------------------------------------------------------------------
	// Field positions
	//--------------------------------------------------------------------------
	localparam int          LFC_DIV_BIT    = 7;
	localparam int          LFC_BRK_BIT    = 6;
	localparam int          LFC_STICK_BIT  = 5;
	localparam int          LFC_POL_BIT    = 4;
	localparam int          LFC_PAR_BIT    = 3;
	localparam int          LFC_STOP_BIT   = 2;
	localparam int          LFC_WL_LSB     = 0;
	localparam int          BSC_DEC_BIT    = 7;
	localparam int          OMC_MODE_LSB   = 5;
	localparam int          OMC_SIP_BIT    = 4;
	localparam int          OMC_TRANSMIT_DELAY_ON_BIT   = 3;
	localparam logic [7:0]  OMC_WR_MASK    = 8'hF8;
	localparam int          EXT_ON_BIT     = 0;
	localparam int          STAT_MODE_LSB  = 0;
	localparam int          STAT_BANK_LSB  = 3;
	localparam int          STAT_TE_BIT    = 6;
	localparam int          STAT_EXT_BIT   = 7;

	//--------------------------------------------------------------------------
	// Format counts and bank numbers
	//--------------------------------------------------------------------------
	localparam logic [1:0]  WL_FIVE        = 2'b00;
	localparam logic [3:0]  MIN_DATA_BITS  = 4'h5;
	localparam logic [2:0]  STOP_HALF_ONE  = 3'h2;
	localparam logic [2:0]  STOP_HALF_1P5  = 3'h3;
	localparam logic [2:0]  STOP_HALF_TWO  = 3'h4;
	localparam logic [1:0]  RX_STOP_BITS   = 2'h1;
	localparam logic [2:0]  BANK_ZERO      = 3'h0;
	localparam logic [2:0]  BANK_ONE       = 3'h1;
	localparam logic [2:0]  BANK_LFC_READ  = 3'h3;
	localparam logic [2:0]  BANK_CODE_MAX  = 3'h5;
	localparam logic [2:0]  BANK_CODE_OFS  = 3'h2;

	//--------------------------------------------------------------------------
	// Enumerations
	//--------------------------------------------------------------------------
	typedef enum logic [2:0] {
		IRFMC_MODE_UART = 3'b000,
		IRFMC_MODE_RSV1 = 3'b001,
		IRFMC_MODE_RSV2 = 3'b010,
		IRFMC_MODE_SIR  = 3'b011,
		IRFMC_MODE_MIR  = 3'b100,
		IRFMC_MODE_FIR  = 3'b101,
		IRFMC_MODE_RSV6 = 3'b110,
		IRFMC_MODE_RSV7 = 3'b111
	} irfmc_mode_t;

	typedef enum logic {
		IRFMC_BUS_IDLE   = 1'b0,
		IRFMC_BUS_ANSWER = 1'b1
	} irfmc_bus_t;

endpackage : irfmc_pkg

/* File: test/irfmc_ctrl_sva.sv */
// Checker of bus timing and configuration outputs of the control block.
module irfmc_ctrl_sva
	import irfmc_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic [2:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        TX_SERIAL_DATA,
	input wire logic        SERIAL_OUT_PIN,
	input wire logic        DIVISOR_ACCESS_SELECT,
	input wire logic        FORMAT_ACTIVE,
	input wire logic [3:0]  DATA_BITS,
	input wire logic [2:0]  TX_STOP_HALF_BITS,
	input wire logic [1:0]  RX_STOP_BITS_OUT,
	input wire logic        PARITY_ON,
	input wire logic        STICK_PARITY,
	input wire logic [2:0]  OPERATING_MODE_SELECT,
	input wire logic        INTERACTION_PULSE_SEND,
	input wire logic        TRANSMIT_DELAY_ON
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// A landing write to the shared index is seen on the outputs two edges later.
	wire lfc_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == LFC_IDX && AVS_BYTEENABLE[0];
	a_wait_one:
		assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("waitrequest not low for exactly one cycle");
	a_upper_zero:
		assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	a_fmt_load:
		assert property (lfc_wr && !AVS_WRITEDATA[7] |-> ##2 DATA_BITS == 4'h5 + $past(AVS_WRITEDATA[1:0], 2))
		else $error("word length not taken from write");
	a_bank_only:
		assert property (lfc_wr && AVS_WRITEDATA[7] |-> ##2 DATA_BITS == $past(DATA_BITS, 2))
		else $error("format changed by bank write");
	a_div_sel:
		assert property (lfc_wr |-> ##2 DIVISOR_ACCESS_SELECT == $past(AVS_WRITEDATA[7], 2))
		else $error("divisor access select not taken from write");
	a_stop_len:
		assert property (TX_STOP_HALF_BITS != 3'h2 |-> TX_STOP_HALF_BITS == ((DATA_BITS == 4'h5) ? 3'h3 : 3'h4))
		else $error("stop length wrong for word length");
	a_rx_stop:
		assert property (RX_STOP_BITS_OUT == 2'h1)
		else $error("receive stop count not one");
	a_stick_par:
		assert property (STICK_PARITY |-> PARITY_ON)
		else $error("stick parity without parity");
	a_break_mode:
		assert property ($past(OPERATING_MODE_SELECT) != 3'h0 && OPERATING_MODE_SELECT != 3'h0
			|-> SERIAL_OUT_PIN == $past(TX_SERIAL_DATA))
		else $error("serial output not following data outside uart");
	a_fmt_mode:
		assert property (FORMAT_ACTIVE == (OPERATING_MODE_SELECT == 3'h0 || OPERATING_MODE_SELECT == 3'h3))
		else $error("format active in wrong mode");
	a_pulse_mode:
		assert property (INTERACTION_PULSE_SEND |-> OPERATING_MODE_SELECT inside {3'h4, 3'h5})
		else $error("pulse outside mir or fir");
	a_delay_mode:
		assert property (TRANSMIT_DELAY_ON |-> OPERATING_MODE_SELECT inside {3'h4, 3'h5})
		else $error("transmit delay outside mir or fir");
	c_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
	c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
	c_break: cover property (!SERIAL_OUT_PIN && TX_SERIAL_DATA);
endmodule : irfmc_ctrl_sva

bind irfmc_ctrl irfmc_ctrl_sva u_sva (.*);

/* File: test/irfmc_ctrl_tb.sv */
// Self-checking bench of the line format, bank and mode control block.
module irfmc_ctrl_tb
	import irfmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk = 0, rst = 1, rd = 0, wr = 0, txd = 1, te = 1;
	logic        wreq, serial_out_pin, divisor_access_select, fact, pon, pst, ppol, pulse, tdly;
	logic [2:0]  adr = 0, stop, mode;
	logic [3:0]  be = 0, dbits;
	logic [1:0]  rxs;
	logic [7:0]  lfc;
	logic [31:0] wdat = 0, rdat, got;
	int          err_total = 0, samples_checked = 0;
	logic [7:0]  par_v [4] = '{8'h38, 8'h18, 8'h08, 8'h30};
	logic [2:0]  par_e [4] = '{3'h7, 3'h5, 3'h4, 3'h1};
	logic [7:0]  bank_v [12] = '{8'h05, 8'h80, 8'hC1, 8'hC2, 8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4, 8'hF8, 8'hC0};
	logic [2:0]  bank_e [12] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h0};
	wire  [19:0] outs = {serial_out_pin, divisor_access_select, fact, dbits, stop, rxs, pon, pst, ppol, mode, pulse, tdly};

	irfmc_ctrl dut (.REF_CLK(ref_clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
		.TX_SERIAL_DATA(txd), .TRANSMIT_ALL_EMPTY_FLAG(te), .SERIAL_OUT_PIN(serial_out_pin), .DIVISOR_ACCESS_SELECT(divisor_access_select),
		.FORMAT_ACTIVE(fact), .DATA_BITS(dbits), .TX_STOP_HALF_BITS(stop), .RX_STOP_BITS_OUT(rxs),
		.PARITY_ON(pon), .STICK_PARITY(pst), .PARITY_POLARITY_SELECT(ppol), .OPERATING_MODE_SELECT(mode),
		.INTERACTION_PULSE_SEND(pulse), .TRANSMIT_DELAY_ON(tdly));

	initial forever #12.5 ref_clk = ~ref_clk;

	task automatic results;
		if (err_total == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
		samples_checked++;
		if (a !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, a);
		end
	endtask : chk

	// The request stands until the rising edge at which waitrequest is sampled low; read data are taken there.
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge ref_clk);
		adr <= a;
		wdat <= 32'(d);
		be <= b;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		got = rdat;
		if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : acc

	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 4'h1);
		repeat (2) @(negedge ref_clk);
	endtask : wreg

	task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 4'h1);
		chk(nm, 32'(e), got);
	endtask : rchk

	task automatic do_reset;
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk("reset_outputs", 32'h000A_A900, 32'(outs));
	endtask : do_reset

	initial begin
		do_reset();
		rchk("shared_reset", LFC_IDX, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wreg(LFC_IDX, 8'(i));
			chk("data_bits", 32'(5 + i % 4), 32'(dbits));
			chk("stop_half", (i < 4) ? 32'h2 : ((i == 4) ? 32'h3 : 32'h4), 32'(stop));
			chk("rx_stop", 32'h1, 32'(rxs));
		end
		foreach (par_v[k]) begin
			wreg(LFC_IDX, par_v[k]);
			chk("parity", 32'(par_e[k]), 32'({pon, pst, ppol}));
		end
		foreach (bank_v[k]) begin
			if (!bank_v[k][7]) lfc = bank_v[k];
			wreg(LFC_IDX, bank_v[k]);
			chk("divisor_sel", 32'(bank_v[k][7]), 32'(divisor_access_select));
			rchk("shared_read", LFC_IDX, (bank_e[k] == 3'h3) ? lfc : bank_v[k]);
			rchk("bank_status", STAT_IDX, {2'b01, bank_e[k], 3'h0});
		end
		acc(1'b1, LFC_IDX, 8'h03, 4'h0);
		wreg(3'h0, 8'hFF);
		rchk("unmapped", 3'h0, 8'h00);
		chk("format_kept", 32'h6, 32'(dbits));
		chk("divisor_sel", 32'h1, 32'(divisor_access_select));
		@(posedge ref_clk);
		te <= 1'b0;
		rchk("te_low", STAT_IDX, 8'h00);
		te <= 1'b1;
		rchk("te_flag", STAT_IDX, 8'h40);
		wreg(LFC_IDX, 8'h40);
		chk("break_uart", 32'h0, 32'(serial_out_pin));
		chk("divisor_off", 32'h0, 32'(divisor_access_select));
		wreg(MLC_IDX, 8'hBF);
		rchk("modem_read", MLC_IDX, 8'h00);
		chk("mode_off", 32'h0, 32'(mode));
		wreg(EXT_IDX, 8'h01);
		rchk("mode_kept", MLC_IDX, 8'h00);
		for (int m = 0; m < 8; m++) begin
			// The transmit FIFO lies outside this block, so the delay bit is only handed on to it.
			wreg(MLC_IDX, {3'(m), 5'h1F});
			rchk("mode_read", MLC_IDX, {3'(m), 5'h18});
			chk("mode_out", 32'(m), 32'(mode));
			chk("fmt_active", 32'(m == 0 || m == 3), 32'(fact));
			chk("pulse_delay", (m == 4 || m == 5) ? 32'h3 : 32'h0, 32'({pulse, tdly}));
			chk("break_out", 32'(m != 0), 32'(serial_out_pin));
		end
		@(posedge ref_clk);
		txd <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("serial_follow", 32'h0, 32'(serial_out_pin));
		wreg(EXT_IDX, 8'h00);
		chk("ext_off", 32'h20, 32'({fact, mode, pulse, tdly}));
		wreg(EXT_IDX, 8'h01);
		wreg(MLC_IDX, 8'hA0);
		rchk("mode_reinit", MLC_IDX, 8'hA0);
		chk("mode_fir", 32'h5, 32'(mode));
		do_reset();
		wreg(EXT_IDX, 8'h01);
		rchk("mode_reset", MLC_IDX, 8'h00);
		results();
	end

	// The sequence needs well under a thousand cycles; this span is far beyond it.
	initial begin
		#100000;
		err_total++;
		results();
	end
endmodule : irfmc_ctrl_tb
